// ==== converter_system_control_defines.vh ====
`ifndef CONVERTER_SYSTEM_CONTROL_DEFINES_VH
`define CONVERTER_SYSTEM_CONTROL_DEFINES_VH

// ==================================================================
// Register offsets
`define REFERENCE_SELECT_ADDR    8'h00
`define SYSTEM_CONTROL_ONE_ADDR  8'h01

// ==================================================================
// Field positions of system_control_one
`define SC1_ENABLE_BIT           7
`define SC1_GO_BIT               6
`define SC1_SLEW_HI              5
`define SC1_SLEW_LO              3
`define SC1_OV_RETRY_BIT         2
`define SC1_OC_HICCUP_BIT        1
`define SC1_MODE_BIT             0

// Field positions of reference_select
`define REF_RESERVED_BIT         7
`define REF_HI                   6

// ==================================================================
// Reset values
`define SC1_ENABLE_RESET         1'b1
`define SC1_GO_RESET             1'b0
`define SC1_SLEW_RESET           3'h4
`define SC1_OV_RETRY_RESET       1'b1
`define SC1_OC_HICCUP_RESET      1'b0
`define SC1_MODE_RESET           1'b0
`define REF_RESET                7'h1e
`define REF_RESERVED_READ        1'b1

// ==================================================================
// Timing
`define CLOCK_MHZ                200
`define REF_STEP_UV              4000
`define SLEW_RATE0_UV_PER_US     40000
`define SLEW_RATE1_UV_PER_US     30000
`define SLEW_RATE2_UV_PER_US     20000
`define SLEW_RATE3_UV_PER_US     10000
`define SLEW_RATE4_UV_PER_US     5000
`define SLEW_RATE5_UV_PER_US     2500
`define SLEW_RATE6_UV_PER_US     1250
`define SLEW_RATE7_UV_PER_US     625
// Cycles per reference step, rounded up so the rate is never exceeded
`define STEP_CYCLES(rate) ((`REF_STEP_UV * `CLOCK_MHZ + (rate) - 1) / (rate))
`define HICCUP_OFF_CYCLES        2000

`endif

// ==== reference_slew.v ====
`include "converter_system_control_defines.vh"

module reference_slew
(
    // Clock and reset
    input  wire       clock_i,
    input  wire       reset_i,
    // Control
    input  wire [6:0] target_i,
    input  wire [2:0] slew_sel_i,
    // Status
    output reg  [6:0] reference_o,
    output wire       at_target_o
);

    // ==================================================================
    // Step interval per slew code
    localparam integer STEP0 = `STEP_CYCLES(`SLEW_RATE0_UV_PER_US);
    localparam integer STEP1 = `STEP_CYCLES(`SLEW_RATE1_UV_PER_US);
    localparam integer STEP2 = `STEP_CYCLES(`SLEW_RATE2_UV_PER_US);
    localparam integer STEP3 = `STEP_CYCLES(`SLEW_RATE3_UV_PER_US);
    localparam integer STEP4 = `STEP_CYCLES(`SLEW_RATE4_UV_PER_US);
    localparam integer STEP5 = `STEP_CYCLES(`SLEW_RATE5_UV_PER_US);
    localparam integer STEP6 = `STEP_CYCLES(`SLEW_RATE6_UV_PER_US);
    localparam integer STEP7 = `STEP_CYCLES(`SLEW_RATE7_UV_PER_US);

    reg  [10:0] interval;
    reg  [10:0] count_r;

    always @*
    begin
        case (slew_sel_i)
            3'h0:    interval = STEP0[10:0];
            3'h1:    interval = STEP1[10:0];
            3'h2:    interval = STEP2[10:0];
            3'h3:    interval = STEP3[10:0];
            3'h4:    interval = STEP4[10:0];
            3'h5:    interval = STEP5[10:0];
            3'h6:    interval = STEP6[10:0];
            default: interval = STEP7[10:0];
        endcase
    end

    assign at_target_o = (reference_o == target_i);

    // ==================================================================
    // Linear ramp, one code step per interval
    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            reference_o <= `REF_RESET;
            count_r     <= 11'h000;
        end
        else if (at_target_o)
        begin
            count_r <= 11'h000;
        end
        else if (count_r >= interval - 11'd1)
        begin
            count_r <= 11'h000;
            if (target_i > reference_o)
                reference_o <= reference_o + 7'h01;
            else
                reference_o <= reference_o - 7'h01;
        end
        else
        begin
            count_r <= count_r + 11'h001;
        end
    end

endmodule // reference_slew

// ==== converter_system_control_reg.v ====
`include "converter_system_control_defines.vh"

module converter_system_control_reg
#(
    parameter HICCUP_OFF_CYCLES = `HICCUP_OFF_CYCLES
)
(
    // Clock and reset
    input  wire       clock_i,
    input  wire       reset_i,
    // External pins
    input  wire       enable_pin_i,
    input  wire       overvoltage_i,
    input  wire       overcurrent_i,
    input  wire       undervoltage_i,
    // Decoded serial register access
    input  wire       reg_write_i,
    input  wire       reg_read_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    // Converter control
    output wire       serial_enable_o,
    output wire       high_side_switch_en_o,
    output wire       low_side_switch_en_o,
    output wire       forced_pwm_o,
    output wire [6:0] reference_o,
    output wire       hiccup_active_o,
    output wire       latched_off_o
);

    // ==================================================================
    // Pin synchronisers
    reg  [3:0] pin_meta_r;
    reg  [3:0] pin_sync_r;

    always @(posedge clock_i)
    begin
        if (reset_i)
        begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end
        else
        begin
            pin_meta_r <= {undervoltage_i, overcurrent_i, overvoltage_i, enable_pin_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    wire enable_pin = pin_sync_r[0];
    wire ov_fault   = pin_sync_r[1];
    wire ocuv_fault = pin_sync_r[2] & pin_sync_r[3];
    // Pin low holds every register except the pin synchronisers in reset
    wire block_reset = reset_i | ~enable_pin;

    // ==================================================================
    // Registers
    reg        enable_r;
    reg        go_r;
    reg  [2:0] slew_r;
    reg        ov_retry_r;
    reg        oc_hiccup_r;
    reg        mode_r;
    reg  [6:0] target_r;
    reg        pending_r;
    wire       at_target;

    wire wr_ref = reg_write_i & (reg_addr_i == `REFERENCE_SELECT_ADDR);
    wire wr_sc1 = reg_write_i & (reg_addr_i == `SYSTEM_CONTROL_ONE_ADDR);

    always @(posedge clock_i)
    begin
        if (block_reset)
        begin
            enable_r    <= `SC1_ENABLE_RESET;
            go_r        <= `SC1_GO_RESET;
            slew_r      <= `SC1_SLEW_RESET;
            ov_retry_r  <= `SC1_OV_RETRY_RESET;
            oc_hiccup_r <= `SC1_OC_HICCUP_RESET;
            mode_r      <= `SC1_MODE_RESET;
            target_r    <= `REF_RESET;
            pending_r   <= 1'b0;
        end
        else
        begin
            if (wr_sc1)
            begin
                enable_r    <= reg_wdata_i[`SC1_ENABLE_BIT];
                slew_r      <= reg_wdata_i[`SC1_SLEW_HI:`SC1_SLEW_LO];
                ov_retry_r  <= reg_wdata_i[`SC1_OV_RETRY_BIT];
                oc_hiccup_r <= reg_wdata_i[`SC1_OC_HICCUP_BIT];
                mode_r      <= reg_wdata_i[`SC1_MODE_BIT];
            end
            // Host write of the permission bit wins over the self-clear
            if (wr_sc1)
                go_r <= reg_wdata_i[`SC1_GO_BIT];
            else if (pending_r && at_target)
                go_r <= 1'b0;
            if (wr_ref && go_r)
            begin
                target_r  <= reg_wdata_i[`REF_HI:0];
                pending_r <= 1'b1;
            end
            else if (pending_r && at_target)
            begin
                pending_r <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Read-back
    always @(posedge clock_i)
    begin
        if (block_reset)
            reg_rdata_o <= 8'h00;
        else if (reg_read_i)
        begin
            case (reg_addr_i)
                `REFERENCE_SELECT_ADDR:   reg_rdata_o <= {`REF_RESERVED_READ, target_r};
                `SYSTEM_CONTROL_ONE_ADDR: reg_rdata_o <= {enable_r, go_r, slew_r,
                                                          ov_retry_r, oc_hiccup_r, mode_r};
                default:                  reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ==================================================================
    // Reference ramp
    reference_slew u_reference_slew
    (
        .clock_i     (clock_i),
        .reset_i     (block_reset),
        .target_i    (target_r),
        .slew_sel_i  (slew_r),
        .reference_o (reference_o),
        .at_target_o (at_target)
    );

    // ==================================================================
    // Protection
    localparam ST_RUN    = 2'h0;
    localparam ST_HICCUP = 2'h1;
    localparam ST_LATCH  = 2'h2;

    reg  [1:0]  prot_state_r;
    reg  [31:0] hiccup_count_r;

    always @(posedge clock_i)
    begin
        if (block_reset)
        begin
            prot_state_r   <= ST_RUN;
            hiccup_count_r <= 32'h0000_0000;
        end
        else
        begin
            case (prot_state_r)
                ST_RUN:
                begin
                    hiccup_count_r <= 32'h0000_0000;
                    if (ov_fault && !ov_retry_r)
                        prot_state_r <= ST_LATCH;
                    else if (ocuv_fault && oc_hiccup_r)
                        prot_state_r <= ST_HICCUP;
                    else if (ocuv_fault)
                        prot_state_r <= ST_LATCH;
                end
                ST_HICCUP:
                begin
                    if (hiccup_count_r >= HICCUP_OFF_CYCLES - 1)
                        prot_state_r <= ST_RUN;
                    else
                        hiccup_count_r <= hiccup_count_r + 32'h0000_0001;
                end
                ST_LATCH:
                begin
                    prot_state_r <= ST_LATCH;
                end
                default:
                begin
                    prot_state_r <= ST_RUN;
                end
            endcase
        end
    end

    // ==================================================================
    // Outputs
    // Switching pauses two clocks after over-voltage appears at the pin, while it is present
    wire switching = enable_pin & enable_r & (prot_state_r == ST_RUN)
                     & ~ov_fault;

    assign serial_enable_o       = enable_pin;
    assign high_side_switch_en_o = switching;
    assign low_side_switch_en_o  = switching;
    assign forced_pwm_o          = go_r | mode_r;
    assign hiccup_active_o       = (prot_state_r == ST_HICCUP);
    assign latched_off_o         = (prot_state_r == ST_LATCH);

endmodule // converter_system_control_reg

// ==== converter_system_control_reg_chk.sv ====
module converter_system_control_reg_chk
#(
    parameter HICCUP_OFF_CYCLES = 2000
)
(
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       reset_i,
    // Pins and register strobes
    input wire logic       enable_pin_i,
    input wire logic       overvoltage_i,
    input wire logic       reg_write_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    // Converter control
    input wire logic       serial_enable_o,
    input wire logic       high_side_switch_en_o,
    input wire logic       low_side_switch_en_o,
    input wire logic       forced_pwm_o,
    input wire logic [6:0] reference_o,
    input wire logic       hiccup_active_o,
    input wire logic       latched_off_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // ==========================================
    // Properties
    a_pin_low_off: assert property ((!enable_pin_i)[*3] |-> !serial_enable_o
        && !high_side_switch_en_o) else $error("switching with pin low");
    a_switch_pair: assert property (high_side_switch_en_o == low_side_switch_en_o)
        else $error("switch enables differ");
    a_hiccup_off: assert property (hiccup_active_o |-> !high_side_switch_en_o)
        else $error("switching during hiccup");
    a_latch_off: assert property (latched_off_o |-> !low_side_switch_en_o)
        else $error("switching while latched");
    a_latch_holds: assert property (latched_off_o && serial_enable_o |=> latched_off_o)
        else $error("latch released early");
    a_ref_steps: assert property (serial_enable_o && $past(serial_enable_o)
        && $changed(reference_o) |-> reference_o == $past(reference_o) + 7'h01
        || reference_o == $past(reference_o) - 7'h01) else $error("reference jumped");
    a_ovp_off: assert property (overvoltage_i[*3] |-> !high_side_switch_en_o)
        else $error("switching in over-voltage");
    a_pwm_write: assert property (reg_write_i && reg_addr_i == 8'h01 && serial_enable_o
        && (reg_wdata_i[6] || reg_wdata_i[0]) |=> forced_pwm_o) else $error("no forced pwm");
    // Length of the present hiccup off time
    int hiccup_len = 0;
    always @(posedge clock_i)
    begin
        if (reset_i || !hiccup_active_o)
            hiccup_len <= 0;
        else
            hiccup_len <= hiccup_len + 1;
    end
    a_hiccup_len: assert property ($fell(hiccup_active_o) && serial_enable_o
        |-> hiccup_len == HICCUP_OFF_CYCLES) else $error("hiccup off time wrong");
endmodule // converter_system_control_reg_chk

bind converter_system_control_reg converter_system_control_reg_chk
    #(.HICCUP_OFF_CYCLES(HICCUP_OFF_CYCLES)) u_chk (.*);

// ==== host_model.sv ====
module host_model
(
    // Clock
    input  wire logic       clock_i,
    // Register strobes
    output logic            reg_write_i = 1'b0,
    output logic            reg_read_i  = 1'b0,
    output logic      [7:0] reg_addr_i  = 8'h00,
    output logic      [7:0] reg_wdata_i = 8'h00,
    input  wire logic [7:0] reg_rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus shows inverted last value
    task wr(input logic [7:0] a, v);
        @(negedge clock_i);
        reg_write_i = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = v;
        @(negedge clock_i);
        reg_write_i = 1'b0;
        reg_addr_i  = ~a;
        reg_wdata_i = ~v;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clock_i);
        reg_read_i = 1'b1;
        reg_addr_i = a;
        @(negedge clock_i);
        reg_read_i = 1'b0;
        reg_addr_i = ~a;
        v          = reg_rdata_o;
    endtask
endmodule // host_model

// ==== converter_system_control_reg_tb.sv ====
module converter_system_control_reg_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 0, reset_i = 1, enable_pin_i = 1, overvoltage_i = 0;
    logic overcurrent_i = 0, undervoltage_i = 0;
    wire  reg_write_i, reg_read_i, serial_enable_o, forced_pwm_o;
    wire  high_side_switch_en_o, low_side_switch_en_o, hiccup_active_o, latched_off_o;
    wire  [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire  [6:0] reference_o;
    int   err_total = 0, checks = 0, cyc = 0, t0;
    int   iv[8] = '{20, 27, 40, 80, 160, 320, 640, 1280};
    logic [31:0] seed = 32'h0000_42d8;
    logic [7:0]  d, sc1, tg;
    always #2.5 clock_i = ~clock_i;
    converter_system_control_reg #(.HICCUP_OFF_CYCLES(20)) u_converter_system_control_reg (.*);
    host_model u_host_model (.*);
    // ==========================================
    // Helpers
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [15:0] g, e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task cy(int k);
        repeat (k) @(negedge clock_i);
    endtask
    task sw(logic e);
        cy(4);
        chk(high_side_switch_en_o, e);
        chk(low_side_switch_en_o, e);
    endtask
    task step();
        logic [6:0] r;
        r = reference_o;
        for (int n = 0; n < 2000 && reference_o === r; n++) cy(1);
    endtask
    task complete_run();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial
    begin
        cy(12);
        reset_i = 0;
        cy(3);
        u_host_model.rd(8'h01, d);
        chk(d, 8'ha4);
        u_host_model.rd(8'h07, d);
        chk(d, 8'h00);
        u_host_model.wr(8'h00, 8'h55);
        cy(2);
        chk(reference_o, 7'h1e);
        u_host_model.rd(8'h00, d);
        chk(d, 8'h9e);
        for (int c = 0; c < 8; c++)
        begin
            d = rnd();
            sc1 = {2'b11, c[2:0], 2'b10, d[0]};
            u_host_model.wr(8'h01, sc1);
            chk(forced_pwm_o, 1'b1);
            tg = {1'b0, reference_o} + ((c % 2) ? 8'hfe : 8'h02);
            u_host_model.wr(8'h00, tg);
            step();
            t0 = cyc;
            step();
            chk(cyc - t0, iv[c]);
            cy(3);
            chk(reference_o, tg[6:0]);
            u_host_model.rd(8'h01, d);
            chk(d, sc1 & 8'hbf);
            chk(forced_pwm_o, sc1[0]);
            u_host_model.rd(8'h00, d);
            chk(d, {1'b1, tg[6:0]});
        end
        u_host_model.wr(8'h01, 8'h24);
        sw(0);
        u_host_model.wr(8'h01, 8'ha4);
        sw(1);
        overvoltage_i = 1;
        sw(0);
        overvoltage_i = 0;
        sw(1);
        u_host_model.wr(8'h01, 8'ha0);
        overvoltage_i = 1;
        cy(4);
        overvoltage_i = 0;
        sw(0);
        chk(latched_off_o, 1'b1);
        enable_pin_i = 0;
        cy(4);
        chk(serial_enable_o, 1'b0);
        chk(high_side_switch_en_o, 1'b0);
        enable_pin_i = 1;
        cy(4);
        chk(latched_off_o, 1'b0);
        u_host_model.rd(8'h01, d);
        chk(d, 8'ha4);
        u_host_model.wr(8'h01, 8'ha6);
        overcurrent_i = 1;
        undervoltage_i = 1;
        cy(4);
        chk(hiccup_active_o, 1'b1);
        overcurrent_i = 0;
        undervoltage_i = 0;
        cy(25);
        sw(1);
        u_host_model.wr(8'h01, 8'ha4);
        overcurrent_i = 1;
        undervoltage_i = 1;
        cy(4);
        overcurrent_i = 0;
        undervoltage_i = 0;
        sw(0);
        chk(latched_off_o, 1'b1);
        complete_run();
    end
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            complete_run();
        end
    end
endmodule // converter_system_control_reg_tb
